// ===== hw/oag_core.sv
// Operand forming, effective address and branch control datapath
`timescale 1ns/1ns
// Contract
// - Register operands 32 bits, loads sign-extended
// - Misaligned word or longword raises address error
// - Stack pointer accesses longword aligned only; enforced for indirect, post-increment, pre-decrement only
// - Transfer, add, compare-equal immediates sign-extended
// - Test, AND, OR, XOR immediates zero-extended
// - AND immediate clears upper 24 bits
// - Trap immediate zero-extended, times four
// - Wide immediates fetched PC-relative from table
// - Instructions are 16-bit halfwords
// - One basic instruction per cycle
// - Arithmetic on registers; logic may hit memory
// - Unconditional branch runs delay slot first
// - Conditional branch delayed or ordinary form
// - 16x16 multiply in one to two cycles
// - 16x16 plus 64 accumulate in two-three
// - 32x32 multiply/accumulate in two to four
// - Compare sets test flag; add does not
// - Post-increment uses register, then adds size
// - Pre-decrement subtracts size, uses, writes back
// - Four-bit displacement scaled, added to register
// - Indexed adds index zero; global base scaled
// - PC-relative sign-extended doubled, or PC plus register
module oag_core
  import oag_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] insn_i,
  input  wire oag_mode_t   mode_i,
  input  wire oag_size_t   size_i,
  input  wire logic        store_i,
  input  wire logic        logic_mem_i,
  input  wire oag_imm_t    imm_kind_i,
  input  wire logic [3:0]  rn_idx_i,
  input  wire logic [31:0] rn_val_i,
  input  wire logic [31:0] index_register_zero_i,
  input  wire logic [31:0] global_base_register_i,
  input  wire logic [31:0] pc_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        cmp_valid_i,
  input  wire logic        cmp_result_i,
  input  wire logic        add_valid_i,
  input  wire oag_branch_t branch_i,
  input  wire logic        branch_on_true_i,
  input  wire logic [31:0] target_i,
  input  wire logic        mul_start_i,
  input  wire oag_mul_t    mul_kind_i,
  input  wire logic        mul_signed_i,
  input  wire logic [31:0] mul_a_i,
  input  wire logic [31:0] mul_b_i,
  input  wire logic [63:0] mul_acc_i,
  output logic             mem_req_o,
  output logic [31:0]      mem_addr_o,
  output oag_size_t        mem_size_o,
  output logic             mem_we_o,
  output logic             addr_error_o,
  output logic             rf_we_o,
  output logic [3:0]       rf_waddr_o,
  output logic [31:0]      rf_wdata_o,
  output logic [31:0]      imm_o,
  output logic [31:0]      load_data_o,
  output logic             test_flag_o,
  output logic             redirect_o,
  output logic [31:0]      redirect_pc_o,
  output logic [31:0]      fetch_pc_o,
  output logic             mul_busy_o,
  output logic             mul_done_o,
  output logic [63:0]      mul_result_o
);
  typedef enum logic [1:0] {
    OAG_ST_RUN  = 2'b01,
    OAG_ST_SLOT = 2'b10
  } oag_state_t;

  oag_state_t  state_q;
  logic [31:0] target_q;
  logic        test_q;
  logic [31:0] addr_q;
  logic        req_q;
  logic        we_q;
  oag_size_t   size_q;
  logic        err_q;
  logic        rfwe_q;
  logic [3:0]  rfa_q;
  logic [31:0] rfd_q;
  logic [31:0] imm_q;
  logic [31:0] ld_q;
  logic        redir_q;
  logic [31:0] redir_pc_q;
  logic [31:0] fpc_q;

  // Size scale 1, 2 or 4
  wire logic [31:0] step = (size_i == OAG_SZ_BYTE) ? 32'h1
                         : (size_i == OAG_SZ_WORD) ? 32'h2 : 32'h4;
  wire logic [31:0] d4   = {28'h0, insn_i[3:0]};
  wire logic [31:0] d8z  = {24'h0, insn_i[7:0]};
  wire logic [31:0] d8s  = {{24{insn_i[7]}}, insn_i[7:0]};
  wire logic [31:0] d12s = {{20{insn_i[11]}}, insn_i[11:0]};
  wire logic [31:0] d4_s = (size_i == OAG_SZ_BYTE) ? d4
                         : (size_i == OAG_SZ_WORD) ? {d4[30:0], 1'b0} : {d4[29:0], 2'b00};
  wire logic [31:0] d8_s = (size_i == OAG_SZ_BYTE) ? d8z
                         : (size_i == OAG_SZ_WORD) ? {d8z[30:0], 1'b0} : {d8z[29:0], 2'b00};
  wire logic [31:0] pc_imm_off = (size_i == OAG_SZ_LONG) ? {d8z[29:0], 2'b00}
                                                         : {d8z[30:0], 1'b0};
  wire logic [31:0] pre_val  = rn_val_i - step;
  wire logic [31:0] post_val = rn_val_i + step;

  // Effective address by mode
  wire logic [31:0] ea =
      (mode_i == OAG_AM_IND || mode_i == OAG_AM_POSTINC) ? rn_val_i
    : (mode_i == OAG_AM_PREDEC)  ? pre_val
    : (mode_i == OAG_AM_DISP4)   ? rn_val_i + d4_s
    : (mode_i == OAG_AM_INDEXED) ? rn_val_i + index_register_zero_i
    : (mode_i == OAG_AM_GBR)     ? global_base_register_i + d8_s
    : (mode_i == OAG_AM_PC8)     ? pc_i + {d8s[30:0], 1'b0}
    : (mode_i == OAG_AM_PC12)    ? pc_i + {d12s[30:0], 1'b0}
    : (mode_i == OAG_AM_PCREG)   ? pc_i + rn_val_i
    : (mode_i == OAG_AM_PCIMM)   ? pc_i + pc_imm_off
    : 32'h0;

  wire logic is_mem = (mode_i != OAG_AM_REG) && (mode_i != OAG_AM_PC8)
                   && (mode_i != OAG_AM_PC12) && (mode_i != OAG_AM_PCREG);
  wire logic sp_use = (rn_idx_i == SP_INDEX) && (mode_i == OAG_AM_IND
                   || mode_i == OAG_AM_POSTINC || mode_i == OAG_AM_PREDEC);
  wire logic misalign = ((size_i == OAG_SZ_WORD) && ea[0])
                     || ((size_i == OAG_SZ_LONG) && (ea[1:0] != 2'b00));
  wire logic sp_bad   = sp_use && ((size_i != OAG_SZ_LONG) || (ea[1:0] != 2'b00));
  wire logic fire     = clk_en_i && valid_i && is_mem;
  wire logic bad      = misalign || sp_bad;
  wire logic slot_ok  = clk_en_i && valid_i;

  // Immediate forming
  wire logic [31:0] imm_v =
      (imm_kind_i == OAG_IMM_SIGN) ? d8s
    : (imm_kind_i == OAG_IMM_ZERO) ? d8z
    : (imm_kind_i == OAG_IMM_AND)  ? (rn_val_i & d8z)
    : (imm_kind_i == OAG_IMM_TRAP) ? {d8z[29:0], 2'b00}
    : 32'h0;

  // Loaded data sign-extended to a longword
  wire logic [31:0] ld_v = (size_i == OAG_SZ_BYTE) ? {{24{rdata_i[7]}}, rdata_i[7:0]}
                         : (size_i == OAG_SZ_WORD) ? {{16{rdata_i[15]}}, rdata_i[15:0]}
                         : rdata_i;

  wire logic wb_ptr  = fire && !bad && (mode_i == OAG_AM_POSTINC || mode_i == OAG_AM_PREDEC);
  wire logic wb_and  = slot_ok && (imm_kind_i == OAG_IMM_AND) && !logic_mem_i;
  wire logic take_c  = (branch_i == OAG_BR_COND || branch_i == OAG_BR_COND_DS)
                    && (test_q == branch_on_true_i);
  wire logic br_now  = slot_ok && (state_q == OAG_ST_RUN)
                    && (branch_i == OAG_BR_COND) && take_c;
  wire logic br_slot = slot_ok && (state_q == OAG_ST_RUN) && ((branch_i == OAG_BR_UNCOND)
                    || ((branch_i == OAG_BR_COND_DS) && take_c));

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q    <= OAG_ST_RUN;
      target_q   <= 32'h0;
      test_q     <= 1'b0;
      addr_q     <= 32'h0;
      req_q      <= 1'b0;
      we_q       <= 1'b0;
      size_q     <= OAG_SZ_BYTE;
      err_q      <= 1'b0;
      rfwe_q     <= 1'b0;
      rfa_q      <= 4'h0;
      rfd_q      <= 32'h0;
      imm_q      <= 32'h0;
      ld_q       <= 32'h0;
      redir_q    <= 1'b0;
      redir_pc_q <= 32'h0;
      fpc_q      <= 32'h0;
    end
    else if (clk_en_i)
    begin
      req_q   <= fire && !bad;
      err_q   <= fire && bad;
      addr_q  <= fire ? ea : addr_q;
      we_q    <= fire && store_i;
      size_q  <= fire ? size_i : size_q;
      rfwe_q  <= wb_ptr || wb_and;
      rfa_q   <= rn_idx_i;
      rfd_q   <= wb_and ? imm_v : (mode_i == OAG_AM_PREDEC) ? pre_val : post_val;
      imm_q   <= valid_i ? imm_v : imm_q;
      ld_q    <= ld_v;
      // Compare alone updates the flag
      test_q  <= cmp_valid_i ? cmp_result_i : test_q;
      redir_q <= br_now || (valid_i && state_q == OAG_ST_SLOT);
      redir_pc_q <= br_now ? target_i : target_q;
      fpc_q   <= valid_i ? pc_i + 32'h2 : fpc_q;
      if (br_slot)
      begin
        target_q <= target_i;
      end
      case (state_q)
        OAG_ST_RUN:
        begin
          if (br_slot)
          begin
            state_q <= OAG_ST_SLOT;
          end
        end
        OAG_ST_SLOT:
        begin
          if (valid_i)
          begin
            state_q <= OAG_ST_RUN;
          end
        end
        default:
        begin
          state_q <= OAG_ST_RUN;
        end
      endcase
    end
  end

  oag_mul u_mul (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .en_i      (clk_en_i),
    .start_i   (mul_start_i),
    .kind_i    (mul_kind_i),
    .signed_i  (mul_signed_i),
    .a_i       (mul_a_i),
    .b_i       (mul_b_i),
    .acc_i     (mul_acc_i),
    .busy_o    (mul_busy_o),
    .done_o    (mul_done_o),
    .result_o  (mul_result_o)
  );

  assign mem_req_o     = req_q;
  assign mem_addr_o    = addr_q;
  assign mem_size_o    = size_q;
  assign mem_we_o      = we_q;
  assign addr_error_o  = err_q;
  assign rf_we_o       = rfwe_q;
  assign rf_waddr_o    = rfa_q;
  assign rf_wdata_o    = rfd_q;
  assign imm_o         = imm_q;
  assign load_data_o   = ld_q;
  assign test_flag_o   = test_q;
  assign redirect_o    = redir_q;
  assign redirect_pc_o = redir_pc_q;
  assign fetch_pc_o    = fpc_q;

  chk_err_pulse: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && fire && bad |=> addr_error_o && !mem_req_o)
    else $error("bad access");
  chk_err_align: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    mem_req_o |-> !(mem_size_o == OAG_SZ_WORD && mem_addr_o[0]))
    else $error("word odd");
  chk_long_align: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    mem_req_o && mem_size_o == OAG_SZ_LONG |-> mem_addr_o[1:0] == 2'b00)
    else $error("long misaligned");
  chk_sp_long: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    fire && sp_use && size_i != OAG_SZ_LONG |=> addr_error_o && !mem_req_o)
    else $error("stack not longword");
  chk_and_upper: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && wb_and |=> rf_we_o && rf_wdata_o[31:8] == 24'h0)
    else $error("and upper");
  chk_trap_scale: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && valid_i && imm_kind_i == OAG_IMM_TRAP |=> imm_o[31:10] == 22'h0
      && imm_o[1:0] == 2'b00)
    else $error("trap offset");
  chk_predec_wb: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    wb_ptr && mode_i == OAG_AM_PREDEC |=> rf_we_o && rf_wdata_o == mem_addr_o)
    else $error("predec writeback");
  chk_postinc_wb: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    wb_ptr && mode_i == OAG_AM_POSTINC |=> rf_we_o && rf_wdata_o - mem_addr_o == $past(step))
    else $error("postinc writeback");
  chk_flag_hold: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !cmp_valid_i && add_valid_i |=> $stable(test_flag_o))
    else $error("flag moved");
  chk_slot_first: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && br_slot |=> !redirect_o)
    else $error("slot skipped");
  chk_slot_jump: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && valid_i && state_q == OAG_ST_SLOT |=> redirect_o
      && redirect_pc_o == $past(target_q))
    else $error("slot jump");
  chk_cond_now: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && br_now |=> redirect_o && redirect_pc_o == $past(target_i))
    else $error("cond branch");
  chk_mul_lat: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && mul_start_i && !mul_busy_o |-> ##[1:4] mul_done_o)
    else $error("mul late");
  // Low clock enable freezes every output
  chk_freeze_hold: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !clk_en_i |=> $stable(mem_req_o) && $stable(addr_error_o) && $stable(rf_we_o)
      && $stable(fetch_pc_o) && $stable(redirect_o) && $stable(mul_done_o))
    else $error("freeze broken");
  cov_err:    cover property (@(posedge clk_i) addr_error_o);
  cov_slot:   cover property (@(posedge clk_i) state_q == OAG_ST_SLOT ##1 redirect_o);
  cov_mul:    cover property (@(posedge clk_i) mul_done_o);
  cov_freeze: cover property (@(posedge clk_i) !clk_en_i && valid_i);
endmodule // oag_core

// ===== hw/oag_pkg.sv
// Package for the operand and address generation block
package oag_pkg;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned INSN_W        = 16;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned INSN_TIME_NS  = 50;
  localparam int unsigned INSN_CYCLES   = 1;
  localparam int unsigned MUL16_LAT     = 1;
  localparam int unsigned MAC16_LAT     = 2;
  localparam int unsigned MUL32_LAT     = 2;
  localparam logic [3:0]  SP_INDEX      = 4'hF;
  localparam logic [7:0]  AND_KEEP_MASK = 8'hFF;

  typedef enum logic [1:0] {
    OAG_SZ_BYTE = 2'h0,
    OAG_SZ_WORD = 2'h1,
    OAG_SZ_LONG = 2'h2
  } oag_size_t;

  typedef enum logic [3:0] {
    OAG_AM_REG     = 4'h0,
    OAG_AM_IND     = 4'h1,
    OAG_AM_POSTINC = 4'h2,
    OAG_AM_PREDEC  = 4'h3,
    OAG_AM_DISP4   = 4'h4,
    OAG_AM_INDEXED = 4'h5,
    OAG_AM_GBR     = 4'h6,
    OAG_AM_PC8     = 4'h7,
    OAG_AM_PC12    = 4'h8,
    OAG_AM_PCREG   = 4'h9,
    OAG_AM_PCIMM   = 4'hA
  } oag_mode_t;

  typedef enum logic [2:0] {
    OAG_IMM_SIGN = 3'h0,
    OAG_IMM_ZERO = 3'h1,
    OAG_IMM_TRAP = 3'h2,
    OAG_IMM_AND  = 3'h3,
    OAG_IMM_NONE = 3'h4
  } oag_imm_t;

  typedef enum logic [1:0] {
    OAG_BR_NONE    = 2'h0,
    OAG_BR_UNCOND  = 2'h1,
    OAG_BR_COND    = 2'h2,
    OAG_BR_COND_DS = 2'h3
  } oag_branch_t;

  typedef enum logic [1:0] {
    OAG_MUL_16    = 2'h0,
    OAG_MAC_16    = 2'h1,
    OAG_MUL_32    = 2'h2,
    OAG_MAC_32    = 2'h3
  } oag_mul_t;
endpackage

// ===== hw/oag_mul.sv
// Multiply and multiply-accumulate unit with fixed latency per kind
`timescale 1ns/1ns
module oag_mul
  import oag_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        en_i,
  input  wire logic        start_i,
  input  wire oag_mul_t    kind_i,
  input  wire logic        signed_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic [63:0] acc_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [63:0]      result_o
);
  logic [1:0]  cnt_q;
  logic [63:0] res_q;
  logic        busy_q;
  logic        done_q;
  wire  logic        is16    = (kind_i == OAG_MUL_16) || (kind_i == OAG_MAC_16);
  wire  logic [32:0] a_x     = is16 ? {{17{signed_i & a_i[15]}}, a_i[15:0]}
                                    : {signed_i & a_i[31], a_i};
  wire  logic [32:0] b_x     = is16 ? {{17{signed_i & b_i[15]}}, b_i[15:0]}
                                    : {signed_i & b_i[31], b_i};
  wire  logic [65:0] prod    = 66'($signed(a_x) * $signed(b_x));
  wire  logic        acc_on  = (kind_i == OAG_MAC_16) || (kind_i == OAG_MAC_32);
  wire  logic [63:0] sum     = prod[63:0] + (acc_on ? acc_i : 64'h0);
  wire  logic [1:0]  lat     = (kind_i == OAG_MUL_16) ? 2'(MUL16_LAT)
                             : (kind_i == OAG_MAC_16) ? 2'(MAC16_LAT) : 2'(MUL32_LAT);
  wire  logic [63:0] res_n   = (kind_i == OAG_MUL_16) ? {32'h0, sum[31:0]} : sum;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q  <= 2'h0;
      res_q  <= 64'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (en_i)
    begin
      done_q <= 1'b0;
      if (start_i && !busy_q)
      begin
        res_q  <= res_n;
        cnt_q  <= lat - 2'h1;
        busy_q <= (lat != 2'h1);
        done_q <= (lat == 2'h1);
      end
      else if (busy_q)
      begin
        cnt_q  <= cnt_q - 2'h1;
        busy_q <= (cnt_q != 2'h1);
        done_q <= (cnt_q == 2'h1);
      end
    end
  end

  assign busy_o   = busy_q;
  assign done_o   = done_q;
  assign result_o = res_q;
endmodule // oag_mul

// ===== tb/oag_mem_model.sv
// Memory partner that answers data reads of the block
`timescale 1ns/1ns
module oag_mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output logic      [31:0] rdata_o
);
  initial rdata_o = 32'h0;
  // Released bus shows the inverse of the last value
  always @(negedge clk_i)
  begin
    if (req_i)
      rdata_o <= addr_i ^ 32'hC3A596F0;
    else
      rdata_o <= ~rdata_o;
  end
endmodule // oag_mem_model

// ===== tb/tb_operand_address_generation.sv
// Self-checking bench for the operand and address generation block
`timescale 1ns/1ns
`define CMP(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %h, seen %h", nm, e, g); \
    end \
  end
module tb_operand_address_generation;
  import oag_pkg::*;
  typedef struct packed {logic [31:0] due; logic [3:0] w; logic [71:0] v;} oag_note_t;
  logic        clk_i = 0, reset_n_i = 0, clk_en_i = 1, valid_i = 0, store_i = 0;
  logic        logic_mem_i = 0, cmp_valid_i = 0, cmp_result_i = 0, add_valid_i = 0;
  logic        branch_on_true_i = 0, mul_start_i = 0, mul_signed_i = 0;
  logic [15:0] insn_i = 0;
  logic [3:0]  rn_idx_i = 0;
  logic [31:0] rn_val_i = 0, index_register_zero_i = 0, global_base_register_i = 0, pc_i = 0;
  logic [31:0] target_i = 0, mul_a_i = 0, mul_b_i = 0, rdata_i, cyc = 0;
  logic [63:0] mul_acc_i = 0;
  oag_mode_t   mode_i = OAG_AM_REG;
  oag_size_t   size_i = OAG_SZ_BYTE;
  oag_imm_t    imm_kind_i = OAG_IMM_NONE;
  oag_branch_t branch_i = OAG_BR_NONE;
  oag_mul_t    mul_kind_i = OAG_MUL_16;
  logic        mem_req_o, mem_we_o, addr_error_o, rf_we_o, test_flag_o, redirect_o;
  logic        mul_busy_o, mul_done_o;
  logic [3:0]  rf_waddr_o;
  logic [31:0] mem_addr_o, rf_wdata_o, imm_o, load_data_o, redirect_pc_o, fetch_pc_o;
  logic [63:0] mul_result_o;
  oag_size_t   mem_size_o;
  int          checked = 0, mismatches = 0;
  logic [31:0] seed = 32'h8F216630;
  oag_note_t   q[$];
  oag_note_t   n;
  string       nm[8] = '{"mem", "rf", "imm", "flag", "redirect", "mul", "load", "fetch_pc"};
  oag_mode_t   mm[7] = '{OAG_AM_IND, OAG_AM_POSTINC, OAG_AM_PREDEC, OAG_AM_DISP4,
                         OAG_AM_INDEXED, OAG_AM_GBR, OAG_AM_PCIMM};

  oag_core i_dut (
    .clk_i, .reset_n_i, .clk_en_i, .valid_i, .insn_i, .mode_i, .size_i, .store_i,
    .logic_mem_i, .imm_kind_i, .rn_idx_i, .rn_val_i, .index_register_zero_i,
    .global_base_register_i, .pc_i, .rdata_i, .cmp_valid_i, .cmp_result_i, .add_valid_i,
    .branch_i, .branch_on_true_i, .target_i, .mul_start_i, .mul_kind_i, .mul_signed_i,
    .mul_a_i, .mul_b_i, .mul_acc_i, .mem_req_o, .mem_addr_o, .mem_size_o, .mem_we_o,
    .addr_error_o, .rf_we_o, .rf_waddr_o, .rf_wdata_o, .imm_o, .load_data_o, .test_flag_o,
    .redirect_o, .redirect_pc_o, .fetch_pc_o, .mul_busy_o, .mul_done_o, .mul_result_o
  );
  oag_mem_model i_mem (.clk_i(clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o), .rdata_o(rdata_i));

  initial forever #20 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [71:0] obs(input logic [3:0] w);
    case (w)
      0: obs = {addr_error_o, mem_req_o, mem_req_o ? {mem_we_o, mem_size_o, mem_addr_o} : 35'h0};
      1: obs = rf_we_o ? {1'b1, rf_waddr_o, rf_wdata_o} : 72'h0;
      2: obs = imm_o;
      3: obs = test_flag_o;
      4: obs = redirect_o ? {1'b1, redirect_pc_o} : 72'h0;
      5: obs = {mul_busy_o, mul_done_o, mul_done_o ? mul_result_o : 64'h0};
      6: obs = load_data_o;
      default: obs = fetch_pc_o;
    endcase
  endfunction

  task automatic push(input logic [3:0] w, input logic [71:0] v, input int d = 1);
    q.push_back(oag_note_t'{cyc + d, w, v});
  endtask

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Results are compared when their note falls due
  always @(negedge clk_i)
  begin
    while (q.size() > 0 && q[0].due == cyc)
    begin
      n = q.pop_front();
      `CMP(nm[n.w], n.v, obs(n.w))
    end
  end

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic mem(oag_mode_t m, oag_size_t s, logic [3:0] ri, logic [31:0] rv,
                     logic [15:0] in, logic st);
    logic [31:0] a, k;
    logic        e;
    k = (s == OAG_SZ_BYTE) ? 1 : (s == OAG_SZ_WORD) ? 2 : 4;
    case (m)
      OAG_AM_PREDEC:  a = rv - k;
      OAG_AM_DISP4:   a = rv + {28'h0, in[3:0]} * k;
      OAG_AM_INDEXED: a = rv + index_register_zero_i;
      OAG_AM_GBR:     a = global_base_register_i + {24'h0, in[7:0]} * k;
      OAG_AM_PCIMM:   a = pc_i + {24'h0, in[7:0]} * k;
      default:        a = rv;
    endcase
    e = (s == OAG_SZ_WORD && a[0]) || (s == OAG_SZ_LONG && a[1:0] != 2'h0)
        || (ri == 4'hF && (s != OAG_SZ_LONG || a[1:0] != 2'h0));
    {valid_i, rn_idx_i, rn_val_i, insn_i, store_i} = {1'b1, ri, rv, in, st};
    mode_i = m;
    size_i = s;
    imm_kind_i = OAG_IMM_NONE;
    push(0, {e, !e, !e ? {st, s, a} : 35'h0});
    if (!e && (m == OAG_AM_POSTINC || m == OAG_AM_PREDEC))
      push(1, {1'b1, ri, (m == OAG_AM_PREDEC) ? a : rv + k});
    else
      push(1, 72'h0);
    @(negedge clk_i);
  endtask

  task automatic br(oag_branch_t b, logic bt, logic tk);
    logic [31:0] t;
    t = rnd();
    {valid_i, branch_on_true_i, target_i} = {1'b1, bt, t};
    mode_i = OAG_AM_REG;
    branch_i = b;
    push(4, (b == OAG_BR_COND && tk) ? {1'b1, t} : 72'h0);
    @(negedge clk_i);
    branch_i = OAG_BR_NONE;
    if (b != OAG_BR_COND)
    begin
      valid_i = 0;
      push(4, 72'h0);
      @(negedge clk_i);
      valid_i = 1;
      push(4, tk ? {1'b1, t} : 72'h0);
      @(negedge clk_i);
    end
    valid_i = 0;
    push(4, 72'h0);
    @(negedge clk_i);
  endtask

  task automatic mul(oag_mul_t k, logic sg);
    logic [31:0] a, b;
    logic [63:0] c, p, r;
    int          l;
    a = rnd();
    b = rnd();
    c = {rnd(), rnd()};
    {mul_start_i, mul_signed_i, mul_a_i, mul_b_i, mul_acc_i} = {1'b1, sg, a, b, c};
    mul_kind_i = k;
    if (k == OAG_MUL_16 || k == OAG_MAC_16)
      p = sg ? 64'($signed(a[15:0]) * $signed(b[15:0])) : 64'(a[15:0] * b[15:0]);
    else
      p = sg ? 64'($signed(a) * $signed(b)) : {32'h0, a} * {32'h0, b};
    r = (k == OAG_MUL_16) ? {32'h0, p[31:0]} : (k == OAG_MUL_32) ? p : c + p;
    l = (k == OAG_MUL_16) ? MUL16_LAT : (k == OAG_MAC_16) ? MAC16_LAT : MUL32_LAT;
    if (l > 1)
      push(5, {2'b10, 64'h0}, l - 1);
    push(5, {2'b01, r}, l);
    @(negedge clk_i);
    mul_start_i = 0;
    repeat (l + 1) @(negedge clk_i);
  endtask

  initial
  begin
    logic [31:0] r, v, x;
    oag_size_t   s;
    oag_mode_t   m;
    repeat (10) @(negedge clk_i);
    reset_n_i = 1;
    for (int i = 0; i < 60; i++)
    begin
      r = rnd();
      s = oag_size_t'(r[9:8] % 2'h3);
      m = mm[r[31:24] % 8'h7];
      if (m == OAG_AM_PCIMM && s == OAG_SZ_BYTE)
        s = OAG_SZ_LONG;
      index_register_zero_i = rnd();
      global_base_register_i = rnd() & 32'hFFFFFFF0;
      pc_i = rnd() & 32'hFFFFFFFC;
      v = rnd();
      if (r[12])
        v[1:0] = 2'h0;
      mem(m, s, {1'b0, r[18:16]}, v, r[15:0], r[13]);
    end
    mem(OAG_AM_IND, OAG_SZ_LONG, 4'hF, 32'h00001000, 16'h0, 1'b1);
    mem(OAG_AM_PREDEC, OAG_SZ_LONG, 4'hF, 32'h00001004, 16'h0, 1'b1);
    mem(OAG_AM_IND, OAG_SZ_WORD, 4'hF, 32'h00001002, 16'h0, 1'b0);
    mem(OAG_AM_IND, OAG_SZ_LONG, 4'hF, 32'h00001001, 16'h0, 1'b0);
    $display("test done: addressing modes");
    for (int i = 0; i < 3; i++)
    begin
      s = oag_size_t'(i);
      v = rnd() & 32'hFFFFFFFC;
      mem(OAG_AM_IND, s, 4'h2, v, 16'h0, 1'b0);
      valid_i = 0;
      x = v ^ 32'hC3A596F0;
      x = (i == 0) ? {{24{x[7]}}, x[7:0]} : (i == 1) ? {{16{x[15]}}, x[15:0]} : x;
      push(6, x);
      @(negedge clk_i);
    end
    $display("test done: load extension");
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      x = {24'h0, v[7:0]};
      {valid_i, logic_mem_i} = {1'b1, i[2]};
      mode_i = OAG_AM_REG;
      imm_kind_i = oag_imm_t'(i % 4);
      {insn_i, rn_idx_i, rn_val_i, pc_i} = {v[15:0], v[19:16], rnd(), v};
      case (imm_kind_i)
        OAG_IMM_SIGN: push(2, {{24{v[7]}}, v[7:0]});
        OAG_IMM_ZERO: push(2, x);
        OAG_IMM_TRAP: push(2, x << 2);
        default:      push(1, i[2] ? 72'h0 : {1'b1, v[19:16], rn_val_i & x});
      endcase
      push(7, 32'(v + 32'h2));
      @(negedge clk_i);
    end
    {valid_i, logic_mem_i} = 2'b00;
    imm_kind_i = OAG_IMM_NONE;
    // Frozen cycle must keep the last fetch address
    clk_en_i = 0;
    {valid_i, pc_i} = {1'b1, ~v};
    push(7, 32'(v + 32'h2));
    @(negedge clk_i);
    {clk_en_i, valid_i} = 2'b10;
    $display("test done: immediates");
    for (int i = 0; i < 4; i++)
    begin
      {cmp_valid_i, add_valid_i, cmp_result_i} = {~i[0], i[0], ~i[1] ^ i[0]};
      push(3, {71'h0, ~i[1]});
      @(negedge clk_i);
    end
    {cmp_valid_i, add_valid_i} = 2'h0;
    br(OAG_BR_UNCOND, 1'b1, 1'b1);
    br(OAG_BR_COND, 1'b0, 1'b1);
    br(OAG_BR_COND, 1'b1, 1'b0);
    br(OAG_BR_COND_DS, 1'b0, 1'b1);
    br(OAG_BR_COND_DS, 1'b1, 1'b0);
    $display("test done: flag and branches");
    for (int i = 0; i < 8; i++)
      mul(oag_mul_t'(i % 4), i[2]);
    $display("test done: multiply");
    repeat (4) @(negedge clk_i);
    end_of_test();
  end
endmodule // tb_operand_address_generation
